// ===== bench/bus_host.sv
// Host model on the decoded transaction port
`default_nettype none
module bus_host
(
	input wire logic I_MCLK, o_RD_VALID,
	input wire logic [7:0] o_RD_DATA,
	output logic [7:0] i_CMD_CODE, i_WR_BYTE,
	output logic i_XFER_START, i_WR_BYTE_VALID, i_XFER_END, i_RD_REQ
);
	timeunit 1ns;
	timeprecision 100ps;
	initial {i_CMD_CODE, i_WR_BYTE, i_XFER_START, i_WR_BYTE_VALID, i_XFER_END, i_RD_REQ} = '0;
	// Count byte, payload low byte first, then stop
	task automatic wr(input logic [7:0] c, n, input logic [39:0] v);
		@(posedge I_MCLK);
		i_CMD_CODE <= c;
		i_XFER_START <= 1'h1;
		for (int k = 0; k <= n && c == 8'hB1; k++)
		begin
			@(posedge I_MCLK);
			{i_XFER_START, i_WR_BYTE_VALID} <= 2'h1;
			i_WR_BYTE <= k ? v[8*k-8 +: 8] : n;
		end
		@(posedge I_MCLK);
		{i_XFER_START, i_WR_BYTE_VALID, i_XFER_END} <= 3'h1;
		i_WR_BYTE <= ~i_WR_BYTE;
		@(posedge I_MCLK);
		i_XFER_END <= 1'h0;
	endtask
	// Six requests, answers gathered low byte first
	task automatic rd(output logic [47:0] q);
		q = '0;
		@(posedge I_MCLK);
		i_CMD_CODE <= 8'hB1;
		i_XFER_START <= 1'h1;
		@(posedge I_MCLK);
		{i_XFER_START, i_RD_REQ} <= 2'h1;
		for (int k = 1; k < 9; k++)
		begin
			@(posedge I_MCLK);
			i_RD_REQ <= k < 6;
			// Answer is taken once it has settled
			@(negedge I_MCLK);
			if (o_RD_VALID)
				q = {o_RD_DATA, q[47:8]};
		end
	endtask
endmodule
`default_nettype wire

// ===== bench/loop_comp_chk.sv
// Property checks on the compensation register ports
`default_nettype none
module loop_comp_chk
(
	input wire logic I_MCLK, I_SYS_RST, i_RD_REQ, i_XFER_END, i_ANALOG_SUPPLY_INPUT_UVLO,
	input wire logic i_NVM_LOAD_VALID, o_RD_VALID, o_WR_ERR, o_HW_PENDING,
	input wire logic [7:0] i_CMD_CODE,
	input wire logic [39:0] i_NVM_LOAD_DATA, o_REG_VALUE,
	input wire logic [1:0] o_CUR_TRANSCOND_SEL
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (I_SYS_RST);
	rd_answer_a: assert property (i_RD_REQ && i_CMD_CODE == 8'hB1 |=> o_RD_VALID)
		else $error("read unanswered");
	rd_cause_a: assert property (o_RD_VALID |-> $past(i_RD_REQ))
		else $error("stray read answer");
	err_pulse_a: assert property (o_WR_ERR |-> $past(i_XFER_END) ##1 !o_WR_ERR)
		else $error("bad error pulse");
	hw_match_a: assert property (!o_HW_PENDING |-> o_CUR_TRANSCOND_SEL == o_REG_VALUE[1:0])
		else $error("hardware differs");
	reg_hold_a: assert property (!$past(i_XFER_END) && !$past(i_NVM_LOAD_VALID)
		|-> $stable(o_REG_VALUE)) else $error("register moved");
	load_in_a: assert property (i_NVM_LOAD_VALID |=> !o_HW_PENDING
		&& o_REG_VALUE == $past(i_NVM_LOAD_DATA)) else $error("load missed");
	uvlo_apply_a: assert property (i_ANALOG_SUPPLY_INPUT_UVLO [*3] |-> !o_HW_PENDING)
		else $error("lockout ignored");
	pend_set_a: assert property ($rose(o_HW_PENDING) |-> $past(i_XFER_END))
		else $error("stray pending");
endmodule
bind loop_compensation_config_reg loop_comp_chk i_chk (.*);
`default_nettype wire

// ===== bench/loop_compensation_config_reg_bench.sv
// Self-checking bench for the compensation register
`default_nettype none
module loop_compensation_config_reg_bench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [39:0] KEEP = 40'hFFFFFEFF33;
	logic I_MCLK = 1'h0, I_SYS_RST = 1'h1, i_CONV_EN = 1'h0, i_ANALOG_SUPPLY_INPUT_UVLO = 1'h0;
	logic i_NVM_LOAD_VALID = 1'h0;
	logic [39:0] i_NVM_LOAD_DATA = '0, d, old;
	logic [47:0] q;
	int seed = 32'h41cfe625, bad_count = 0, total_checks = 0;
	wire logic [7:0] i_CMD_CODE, i_WR_BYTE, o_RD_DATA;
	wire logic i_XFER_START, i_WR_BYTE_VALID, i_XFER_END, i_RD_REQ, o_RD_VALID, o_WR_ERR;
	wire logic o_HW_PENDING, o_CUR_INTEG_CAP_DOUBLER;
	wire logic [39:0] o_REG_VALUE;
	wire logic [3:0] o_CUR_INTEG_CAP_SEL, o_VOLT_INTEG_CAP_SEL;
	wire logic [4:0] o_CUR_FILTER_CAP_SEL, o_VOLT_FILTER_CAP_SEL;
	wire logic [5:0] o_CUR_MIDBAND_RES_SEL, o_VOLT_MIDBAND_RES_SEL;
	wire logic [1:0] o_VOLT_TRANSCOND_SEL, o_CUR_TRANSCOND_SEL;
	wire logic [34:0] hw = {o_CUR_INTEG_CAP_SEL, o_CUR_INTEG_CAP_DOUBLER, o_CUR_FILTER_CAP_SEL,
		o_CUR_MIDBAND_RES_SEL, o_VOLT_INTEG_CAP_SEL, o_VOLT_FILTER_CAP_SEL,
		o_VOLT_MIDBAND_RES_SEL, o_VOLT_TRANSCOND_SEL, o_CUR_TRANSCOND_SEL};
	loop_compensation_config_reg i_loop_compensation_config_reg (.*);
	bus_host i_bus_host (.*);
	always #12.5 I_MCLK = ~I_MCLK;
	function automatic logic [34:0] fld(input logic [39:0] r);
		// Also
		return {r[25:24], r[39:38], r[32], r[37:33], r[31:26], r[9:8], r[23:22],
			r[21:17], r[15:10], r[5:4], r[1:0]};
	endfunction
	task automatic chk(input logic [75:0] got, exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic st(input logic [39:0] r, h, input logic p);
		chk({o_REG_VALUE, hw, o_HW_PENDING}, {r, fld(h), p});
	endtask
	task automatic close_out;
		$display("checks=%0d bad=%0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge I_MCLK);
		I_SYS_RST <= 1'h0;
		d = 40'({$random(seed), $random(seed)}) & KEEP;
		{i_NVM_LOAD_VALID, i_NVM_LOAD_DATA} <= {1'h1, d};
		@(posedge I_MCLK);
		{i_NVM_LOAD_VALID, i_NVM_LOAD_DATA} <= {1'h0, ~d};
		repeat (2) @(posedge I_MCLK);
		st(d, d, 1'h0);
		$display("test load done");
		for (int i = 0; i < 7; i++)
		begin
			old = d;
			d = i ? 40'({$random(seed), $random(seed)}) & KEEP : KEEP;
			i_CONV_EN <= i > 4;
			i_bus_host.wr(8'hB1, 8'h05, d);
			@(negedge I_MCLK);
			chk(o_WR_ERR, 1'h0);
			repeat (3) @(posedge I_MCLK);
			st(d, i > 4 ? old : d, i > 4);
			i_bus_host.rd(q);
			chk(q, {d, 8'h05});
			i_bus_host.wr(8'hB1, 8'h04, ~d);
			@(negedge I_MCLK);
			chk(o_WR_ERR, 1'h1);
			repeat (3) @(posedge I_MCLK);
			st(d, i > 4 ? old : d, i > 4);
			i_ANALOG_SUPPLY_INPUT_UVLO <= i == 6;
			if (i == 5)
			begin
				i_bus_host.wr(8'h15, 8'h00, d);
				i_bus_host.wr(8'h16, 8'h00, d);
			end
			repeat (4) @(posedge I_MCLK);
			st(d, d, 1'h0);
			i_ANALOG_SUPPLY_INPUT_UVLO <= 1'h0;
		end
		$display("test writes done");
		close_out();
	end
	initial
	begin
		#(25 * 3000);
		bad_count++;
		close_out();
	end
endmodule
`default_nettype wire

// ===== logic/loop_comp_pkg.sv
// Constants for the loop compensation configuration register
`default_nettype none
package loop_comp_pkg;
	localparam logic [7:0] CMD_LOOP_COMP    = 8'hB1;
	localparam logic [7:0] CMD_STORE_ALL    = 8'h15;
	localparam logic [7:0] CMD_RESTORE_ALL  = 8'h16;
	localparam int         REG_W            = 40;
	localparam logic [7:0] PAYLOAD_BYTES    = 8'h05;
	localparam logic [2:0] LAST_BYTE_IDX    = 3'h5;
	localparam logic [7:0] RD_FILL          = 8'hFF;
	localparam int CZI_LO_MSB = 39;
	localparam int CZI_LO_LSB = 38;
	localparam int CPI_MSB    = 37;
	localparam int CPI_LSB    = 33;
	localparam int CZI_MUL    = 32;
	localparam int RVI_MSB    = 31;
	localparam int RVI_LSB    = 26;
	localparam int CZI_HI_MSB = 25;
	localparam int CZI_HI_LSB = 24;
	localparam int CZV_LO_MSB = 23;
	localparam int CZV_LO_LSB = 22;
	localparam int CPV_MSB    = 21;
	localparam int CPV_LSB    = 17;
	localparam int RVV_MSB    = 15;
	localparam int RVV_LSB    = 10;
	localparam int CZV_HI_MSB = 9;
	localparam int CZV_HI_LSB = 8;
	localparam int GMV_MSB    = 5;
	localparam int GMV_LSB    = 4;
	localparam int GMI_MSB    = 1;
	localparam int GMI_LSB    = 0;
endpackage
`default_nettype wire

// ===== logic/loop_compensation_config_reg.sv
// Loop compensation configuration register with hardware update gating
`default_nettype none
module loop_compensation_config_reg
	import loop_comp_pkg::*;
(
	// Clock and reset
	input  wire logic        I_MCLK,
	input  wire logic        I_SYS_RST,
	// Decoded bus transaction
	input  wire logic [7:0]  i_CMD_CODE,
	input  wire logic        i_XFER_START,
	input  wire logic        i_WR_BYTE_VALID,
	input  wire logic [7:0]  i_WR_BYTE,
	input  wire logic        i_XFER_END,
	input  wire logic        i_RD_REQ,
	// Device state
	input  wire logic        i_CONV_EN,
	input  wire logic        i_ANALOG_SUPPLY_INPUT_UVLO,
	input  wire logic        i_NVM_LOAD_VALID,
	input  wire logic [39:0] i_NVM_LOAD_DATA,
	// Read answer and register status
	output logic [7:0]       o_RD_DATA,
	output logic             o_RD_VALID,
	output logic             o_WR_ERR,
	output logic             o_HW_PENDING,
	output logic [39:0]      o_REG_VALUE,
	// Control loop hardware
	output logic [3:0]       o_CUR_INTEG_CAP_SEL,
	output logic             o_CUR_INTEG_CAP_DOUBLER,
	output logic [4:0]       o_CUR_FILTER_CAP_SEL,
	output logic [5:0]       o_CUR_MIDBAND_RES_SEL,
	output logic [3:0]       o_VOLT_INTEG_CAP_SEL,
	output logic [4:0]       o_VOLT_FILTER_CAP_SEL,
	output logic [5:0]       o_VOLT_MIDBAND_RES_SEL,
	output logic [1:0]       o_VOLT_TRANSCOND_SEL,
	output logic [1:0]       o_CUR_TRANSCOND_SEL
);
	typedef struct packed {
		logic [REG_W-1:0] reg_val;
		logic [REG_W-1:0] hw_val;
		logic [REG_W-1:0] wbuf;
		logic [REG_W-1:0] rd_sh;
		logic [7:0]       wlen;
		logic [2:0]       widx;
		logic [2:0]       ridx;
		logic             wr_ovf;
		logic             pending;
		logic             stored;
		logic [7:0]       rd_data;
		logic             rd_valid;
		logic             wr_err;
	} state_s;

	state_s st;
	state_s next_st;
	logic   sel;

	assign sel = (i_CMD_CODE == CMD_LOOP_COMP);

	always_comb
	begin
		next_st          = st;
		next_st.rd_valid = 1'b0;
		next_st.wr_err   = 1'b0;
		if (i_XFER_START)
		begin
			next_st.widx   = 3'h0;
			next_st.ridx   = 3'h0;
			next_st.wr_ovf = 1'b0;
			next_st.rd_sh  = st.reg_val;
		end
		// Byte 0 is the block count, then payload low byte first
		if (i_WR_BYTE_VALID && sel)
		begin
			if (st.widx == 3'h0)
				next_st.wlen = i_WR_BYTE;
			else if (st.widx <= LAST_BYTE_IDX)
				next_st.wbuf = {i_WR_BYTE, st.wbuf[REG_W-1:8]};
			else
				next_st.wr_ovf = 1'b1;
			if (st.widx <= LAST_BYTE_IDX)
				next_st.widx = st.widx + 3'h1;
		end
		if (i_XFER_END && sel && (st.widx != 3'h0))
		begin
			if ((st.wlen == PAYLOAD_BYTES) && (st.widx == LAST_BYTE_IDX + 3'h1) && !st.wr_ovf)
			begin
				next_st.reg_val = st.wbuf;
				if (!i_CONV_EN)
				begin
					next_st.hw_val  = st.wbuf;
					next_st.pending = 1'b0;
				end
				else
				begin
					next_st.pending = 1'b1;
					next_st.stored  = 1'b0;
				end
			end
			else
				next_st.wr_err = 1'b1;
		end
		// Store then restore releases a blocked value
		if (i_XFER_END && (i_CMD_CODE == CMD_STORE_ALL) && st.pending)
			next_st.stored = 1'b1;
		if (i_XFER_END && (i_CMD_CODE == CMD_RESTORE_ALL) && st.pending && st.stored)
		begin
			next_st.hw_val  = st.reg_val;
			next_st.pending = 1'b0;
			next_st.stored  = 1'b0;
		end
		if (i_ANALOG_SUPPLY_INPUT_UVLO)
		begin
			next_st.hw_val  = next_st.reg_val;
			next_st.pending = 1'b0;
			next_st.stored  = 1'b0;
		end
		// Backup or strap load sets both copies
		if (i_NVM_LOAD_VALID)
		begin
			next_st.reg_val = i_NVM_LOAD_DATA;
			next_st.hw_val  = i_NVM_LOAD_DATA;
			next_st.pending = 1'b0;
			next_st.stored  = 1'b0;
		end
		// Block read: count byte, then payload low byte first
		if (i_RD_REQ && sel)
		begin
			next_st.rd_valid = 1'b1;
			if (st.ridx == 3'h0)
				next_st.rd_data = PAYLOAD_BYTES;
			else if (st.ridx <= LAST_BYTE_IDX)
			begin
				next_st.rd_data = st.rd_sh[7:0];
				next_st.rd_sh   = {8'h00, st.rd_sh[REG_W-1:8]};
			end
			else
				next_st.rd_data = RD_FILL;
			if (st.ridx <= LAST_BYTE_IDX)
				next_st.ridx = st.ridx + 3'h1;
		end
	end

	always_ff @(posedge I_MCLK or posedge I_SYS_RST)
	begin
		if (I_SYS_RST)
			st <= '0;
		else
			st <= next_st;
	end

	assign o_RD_DATA    = st.rd_data;
	assign o_RD_VALID   = st.rd_valid;
	assign o_WR_ERR     = st.wr_err;
	assign o_HW_PENDING = st.pending;
	assign o_REG_VALUE  = st.reg_val;
	// Field split of the applied copy
	assign o_CUR_INTEG_CAP_SEL = {st.hw_val[CZI_HI_MSB:CZI_HI_LSB],
		st.hw_val[CZI_LO_MSB:CZI_LO_LSB]};
	assign o_CUR_INTEG_CAP_DOUBLER = st.hw_val[CZI_MUL];
	assign o_CUR_FILTER_CAP_SEL    = st.hw_val[CPI_MSB:CPI_LSB];
	assign o_CUR_MIDBAND_RES_SEL   = st.hw_val[RVI_MSB:RVI_LSB];
	assign o_VOLT_INTEG_CAP_SEL = {st.hw_val[CZV_HI_MSB:CZV_HI_LSB],
		st.hw_val[CZV_LO_MSB:CZV_LO_LSB]};
	assign o_VOLT_FILTER_CAP_SEL  = st.hw_val[CPV_MSB:CPV_LSB];
	assign o_VOLT_MIDBAND_RES_SEL = st.hw_val[RVV_MSB:RVV_LSB];
	assign o_VOLT_TRANSCOND_SEL   = st.hw_val[GMV_MSB:GMV_LSB];
	assign o_CUR_TRANSCOND_SEL    = st.hw_val[GMI_MSB:GMI_LSB];
endmodule
`default_nettype wire
